// ===== swd_map.vh
// Constants of the single-wire debug command unit: timing, fields, offsets.
// Summary of operation
// - Each command except speed measurement begins with an 8-bit code, MSB first.
// - A delay slot is 16 debug-clock cycles; the unit finishes its access there.
// - Addresses are 16 bits inbound; bytes are 8 bits, pairs 16 bits.
// - Status field returns the status/control byte; control field writes it.
// - Code 0x90 enters background mode, ignored while background permit is 0.
// - 0xE4 reads status, 0xC4 writes control, both accepted at any time.
// - 0xE0 reads a memory byte at an address; 0xE1 sends status first.
// - 0xE8 sends status then re-reads the last read address.
// - 0xC0 writes a memory byte at an address; 0xC1 then returns status.
// - 0xE2 reads and 0xC2 writes the 16-bit match register, halted or not.
// - Halted only: 0x08 resumes, 0x18 resumes tagged, 0x10 single steps.
// - Halted only: read accumulator, flags, program counter, index pair, stack pointer.
// - Halted only: write accumulator, flags, program counter, index pair, stack pointer.
// - 0x70 increments index pair then reads; 0x71 sends status first.
// - 0x50 increments index pair then writes; 0x51 then returns status.
// - After the request ends: wait 16, drive low 128, high 1, release.
// - Breakpoint compares the processor address bus with the 16-bit match value.
// - Forced mode: any access to the match address halts at next boundary.
// - Tagged mode: opcode fetched at the match address is marked for halt.
// - Breakpoint enable resets to 0 and then suppresses every breakpoint.
// - Force/tag select 1 picks forced breakpoints, 0 picks tagged ones.
// - Background-only commands run only while halted; others run any time.
// - Each bit starts at a host falling edge and lasts 16 cycles, MSB first.
// - 512 cycles between host falling edges abort the command without side effects; a timeout during the reply comes after the access.
`ifndef SWD_MAP_VH
`define SWD_MAP_VH
`define SWD_BIT_CYCLES 8'h10
`define SWD_RX_SAMPLE 8'h0a
`define SWD_TX_ONE_PULSE 8'h07
`define SWD_TX_ZERO_LOW 8'h0d
`define SWD_DELAY_CYCLES 8'h10
`define SWD_SYNC_DETECT 8'h80
`define SWD_SYNC_LOW 8'h80
`define SWD_TIMEOUT 10'h200
`define SWD_ALT_DIV_RST 8'h03
`define SWD_ST_PERMIT 7
`define SWD_ST_ACTIVE 6
`define SWD_ST_BKPT_EN 5
`define SWD_ST_FTS 4
`define SWD_ST_CLKSW 3
`define SWD_APB_STATUS 8'h00
`define SWD_APB_MATCH 8'h04
`define SWD_APB_DIV 8'h08
`define SWD_APB_INFO 8'h0c
`define SWD_INFO_TIMEOUT 9
`endif

// ===== swd_line_phy.v
// Bit engine of the debug line: synchroniser, bit timing, timeout and speed response.
`timescale 1ns/1ps
`include "swd_map.vh"
module swd_line_phy (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_tick,
  input wire i_debug_line,
  output reg o_debug_line,
  output reg o_debug_line_oe,
  input wire i_tx_mode,
  input wire i_tx_bit,
  input wire i_busy,
  output reg o_bit_done,
  output reg o_rx_bit,
  output reg o_sync_done,
  output reg o_timeout
);
  localparam P_IDLE = 3'd0, P_RX = 3'd1, P_RXLOW = 3'd2, P_TX = 3'd3;
  localparam P_SWAIT = 3'd4, P_SDLY = 3'd5, P_SLOW = 3'd6, P_SHI = 3'd7;
  reg s1, s2, s3, lvl, lvl_q, txb;
  reg [2:0] state;
  reg [7:0] cnt;
  reg [9:0] tocnt;
  reg drv_oe, drv_out;
  wire fall = lvl_q & ~lvl;

  // The pin is foreign to the clock; a level counts once stages two and three agree.
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      lvl <= 1'b1;
      lvl_q <= 1'b1;
    end else begin
      s1 <= i_debug_line;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) lvl <= s3;
      lvl_q <= lvl;
    end
  end

  // Drive pattern per state; the target speeds up rising edges with short high pulses.
  always @* begin
    drv_oe = 1'b0;
    drv_out = 1'b0;
    case (state)
      P_TX: begin
        if (txb) begin
          drv_oe = (cnt == `SWD_TX_ONE_PULSE);
          drv_out = 1'b1;
        end else begin
          drv_oe = (cnt <= `SWD_TX_ZERO_LOW);
          drv_out = (cnt == `SWD_TX_ZERO_LOW);
        end
      end
      P_SLOW: drv_oe = 1'b1;
      P_SHI: begin
        drv_oe = 1'b1;
        drv_out = 1'b1;
      end
      default: drv_oe = 1'b0;
    endcase
  end

  // Bit and speed-response sequencer, counted in debug-clock ticks.
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= P_IDLE;
      cnt <= 8'h00;
      txb <= 1'b1;
      o_bit_done <= 1'b0;
      o_rx_bit <= 1'b0;
      o_sync_done <= 1'b0;
      o_debug_line <= 1'b0;
      o_debug_line_oe <= 1'b0;
    end else begin
      o_bit_done <= 1'b0;
      o_sync_done <= 1'b0;
      o_debug_line <= drv_out;
      o_debug_line_oe <= drv_oe;
      case (state)
        P_IDLE: begin
          cnt <= 8'h00;
          txb <= i_tx_bit;
          if (fall) state <= i_tx_mode ? P_TX : P_RX;
        end
        P_RX: if (i_tick) begin
          cnt <= cnt + 8'h01;
          if (cnt == `SWD_RX_SAMPLE - 8'h01) begin
            o_rx_bit <= lvl;
            o_bit_done <= 1'b1;
            state <= lvl ? P_IDLE : P_RXLOW;
          end
        end
        P_RXLOW: begin
          if (lvl) state <= P_IDLE;
          else if (i_tick) begin
            cnt <= cnt + 8'h01;
            if (cnt == `SWD_SYNC_DETECT - 8'h01) state <= P_SWAIT;
          end
        end
        P_TX: if (i_tick) begin
          cnt <= cnt + 8'h01;
          if (cnt == `SWD_BIT_CYCLES - 8'h01) begin
            o_bit_done <= 1'b1;
            state <= P_IDLE;
          end
        end
        P_SWAIT: begin
          cnt <= 8'h00;
          if (lvl) state <= P_SDLY;
        end
        P_SDLY: if (i_tick) begin
          cnt <= cnt + 8'h01;
          if (cnt == `SWD_DELAY_CYCLES - 8'h01) begin
            cnt <= 8'h00;
            state <= P_SLOW;
          end
        end
        P_SLOW: if (i_tick) begin
          cnt <= cnt + 8'h01;
          if (cnt == `SWD_SYNC_LOW - 8'h01) state <= P_SHI;
        end
        P_SHI: if (i_tick) begin
          o_sync_done <= 1'b1;
          state <= P_IDLE;
        end
        default: state <= P_IDLE;
      endcase
    end
  end

  // Ticks since the last falling edge; a stalled host aborts only a command in progress.
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tocnt <= 10'h000;
      o_timeout <= 1'b0;
    end else begin
      o_timeout <= i_tick & (tocnt == `SWD_TIMEOUT - 10'h001) & i_busy;
      if (fall) tocnt <= 10'h000;
      else if (i_tick && tocnt != `SWD_TIMEOUT) tocnt <= tocnt + 10'h001;
    end
  end
endmodule // swd_line_phy

// ===== swd_cmd_unit.v
// Command layer, breakpoint logic and bus slave of the single-wire debug unit.
`timescale 1ns/1ps
`include "swd_map.vh"
module swd_cmd_unit (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_debug_line,
  output wire o_debug_line,
  output wire o_debug_line_oe,
  input wire i_cpu_halted,
  output reg o_bgnd_req,
  output reg o_resume,
  output reg o_resume_tagged,
  output reg o_single_step,
  output reg o_reg_req,
  output reg o_reg_we,
  output reg [2:0] o_reg_sel,
  output reg [15:0] o_reg_wdata,
  input wire [15:0] i_reg_rdata,
  input wire i_reg_ack,
  input wire [15:0] i_index,
  output reg o_index_inc,
  output reg o_mem_req,
  output reg o_mem_we,
  output reg [15:0] o_mem_addr,
  output reg [7:0] o_mem_wdata,
  input wire [7:0] i_mem_rdata,
  input wire i_mem_ack,
  input wire [15:0] i_cpu_addr,
  input wire i_cpu_access,
  input wire i_opcode_fetch,
  output reg o_force_bkpt,
  output reg o_tag_opcode
);
  // ****************************************************************
  // Local encodings
  // ****************************************************************
  localparam M_CMD = 3'd0, M_DEC = 3'd1, M_RX = 3'd2, M_ACC = 3'd3;
  localparam M_WAIT = 3'd4, M_TXS = 3'd5, M_TXD = 3'd6;
  localparam A_NONE = 4'd0, A_BGND = 4'd1, A_WCTL = 4'd2, A_MEMRD = 4'd3;
  localparam A_MEMWR = 4'd4, A_RDLAST = 4'd5, A_MATCH_OUT_FIELD = 4'd6, A_MATCH_IN_FIELD = 4'd7;
  localparam A_GO = 4'd8, A_RESUME_TAGGED_CMD = 4'd9, A_TRACE = 4'd10, A_REGRD = 4'd11;
  localparam A_REGWR = 4'd12, A_NXTRD = 4'd13, A_NXTWR = 4'd14;
  localparam W_NONE = 2'd0, W_BYTE = 2'd1, W_WORD = 2'd2;

  reg [2:0] state;
  reg [4:0] bitcnt;
  reg [7:0] cmd;
  reg [23:0] rsh;
  reg [15:0] sh;
  reg [15:0] rdat;
  reg [15:0] last_addr;
  reg [15:0] match;
  reg permit, bkpt_en, force_tag_select, clksw;
  reg inhibit, ignored, tout_seen;
  reg [3:0] act;
  reg f_ss;
  reg [1:0] f_rd, f_wd;
  reg f_addr;
  reg [4:0] rxn;
  reg [3:0] d_act;
  reg d_abm, d_addr, d_ss;
  reg [1:0] d_wd, d_rd;
  reg [7:0] alt_div, divcnt;
  reg tick;
  wire bit_done, rx_bit, sync_done, timeout;
  wire [7:0] status = {permit, i_cpu_halted, bkpt_en, force_tag_select, clksw, 3'b000};
  wire [15:0] word_out_field = rsh[15:0];
  wire [15:0] addr_in = (f_wd != W_NONE) ? rsh[23:8] : rsh[15:0];
  wire [15:0] next_index = i_index + 16'h0001;
  wire tx_mode = (state == M_TXS) || (state == M_TXD);
  wire busy = (state != M_CMD) || (bitcnt != 5'd0);
  wire link_state = (state == M_CMD) || (state == M_RX) || tx_mode;

  // ****************************************************************
  // Debug clock and line engine
  // ****************************************************************
  // The debug clock is a tick: every core cycle on the bus source, divided otherwise.
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      divcnt <= 8'h00;
      tick <= 1'b0;
    end else if (divcnt >= (clksw ? 8'h00 : alt_div)) begin
      divcnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      divcnt <= divcnt + 8'h01;
      tick <= 1'b0;
    end
  end

  swd_line_phy u_phy (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_tick(tick),
    .i_debug_line(i_debug_line),
    .o_debug_line(o_debug_line),
    .o_debug_line_oe(o_debug_line_oe),
    .i_tx_mode(tx_mode),
    .i_tx_bit(sh[15]),
    .i_busy(busy),
    .o_bit_done(bit_done),
    .o_rx_bit(rx_bit),
    .o_sync_done(sync_done),
    .o_timeout(timeout)
  );

  // ****************************************************************
  // Command decode
  // ****************************************************************
  // Every command is a code, optional inbound fields, one action, then optional replies.
  always @* begin
    d_act = A_NONE;
    d_abm = 1'b0;
    d_addr = 1'b0;
    d_wd = W_NONE;
    d_ss = 1'b0;
    d_rd = W_NONE;
    case (cmd)
      8'h90: d_act = A_BGND;
      8'he4: d_ss = 1'b1;
      8'hc4: begin
        d_act = A_WCTL;
        d_wd = W_BYTE;
      end
      8'he0, 8'he1: begin
        d_act = A_MEMRD;
        d_addr = 1'b1;
        d_ss = cmd[0];
        d_rd = W_BYTE;
      end
      8'he8: begin
        d_act = A_RDLAST;
        d_ss = 1'b1;
        d_rd = W_BYTE;
      end
      8'hc0, 8'hc1: begin
        d_act = A_MEMWR;
        d_addr = 1'b1;
        d_wd = W_BYTE;
        d_ss = cmd[0];
      end
      8'he2: begin
        d_act = A_MATCH_IN_FIELD;
        d_rd = W_WORD;
      end
      8'hc2: begin
        d_act = A_MATCH_OUT_FIELD;
        d_wd = W_WORD;
      end
      8'h08: begin
        d_act = A_GO;
        d_abm = 1'b1;
      end
      8'h18: begin
        d_act = A_RESUME_TAGGED_CMD;
        d_abm = 1'b1;
      end
      8'h10: begin
        d_act = A_TRACE;
        d_abm = 1'b1;
      end
      8'h68, 8'h69, 8'h6b, 8'h6c, 8'h6f: begin
        d_act = A_REGRD;
        d_abm = 1'b1;
        d_rd = (cmd[2:0] <= 3'd1) ? W_BYTE : W_WORD;
      end
      8'h48, 8'h49, 8'h4b, 8'h4c, 8'h4f: begin
        d_act = A_REGWR;
        d_abm = 1'b1;
        d_wd = (cmd[2:0] <= 3'd1) ? W_BYTE : W_WORD;
      end
      8'h70, 8'h71: begin
        d_act = A_NXTRD;
        d_abm = 1'b1;
        d_ss = cmd[0];
        d_rd = W_BYTE;
      end
      8'h50, 8'h51: begin
        d_act = A_NXTWR;
        d_abm = 1'b1;
        d_wd = W_BYTE;
        d_ss = cmd[0];
      end
      default: d_act = A_NONE;
    endcase
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  // Side effects happen only after the last inbound bit, so an abort before the replies changes nothing.
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= M_CMD;
      bitcnt <= 5'd0;
      cmd <= 8'h00;
      rsh <= 24'h000000;
      sh <= 16'hffff;
      rdat <= 16'h0000;
      last_addr <= 16'h0000;
      match <= 16'h0000;
      permit <= 1'b0;
      bkpt_en <= 1'b0;
      force_tag_select <= 1'b0;
      clksw <= 1'b0;
      inhibit <= 1'b0;
      ignored <= 1'b0;
      act <= A_NONE;
      f_ss <= 1'b0;
      f_rd <= W_NONE;
      f_wd <= W_NONE;
      f_addr <= 1'b0;
      rxn <= 5'd0;
      o_bgnd_req <= 1'b0;
      o_resume <= 1'b0;
      o_resume_tagged <= 1'b0;
      o_single_step <= 1'b0;
      o_reg_req <= 1'b0;
      o_reg_we <= 1'b0;
      o_reg_sel <= 3'd0;
      o_reg_wdata <= 16'h0000;
      o_index_inc <= 1'b0;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= 16'h0000;
      o_mem_wdata <= 8'h00;
    end else begin
      o_bgnd_req <= 1'b0;
      o_resume <= 1'b0;
      o_resume_tagged <= 1'b0;
      o_single_step <= 1'b0;
      o_index_inc <= 1'b0;
      if ((timeout || sync_done) && link_state) begin
        state <= M_CMD;
        bitcnt <= 5'd0;
        sh <= 16'hffff;
      end else begin
        case (state)
          M_CMD: if (bit_done) begin
            cmd <= {cmd[6:0], rx_bit};
            bitcnt <= bitcnt + 5'd1;
            if (bitcnt == 5'd7) state <= M_DEC;
          end
          M_DEC: begin
            bitcnt <= 5'd0;
            act <= d_act;
            f_ss <= d_ss;
            f_rd <= d_rd;
            f_wd <= d_wd;
            f_addr <= d_addr;
            inhibit <= d_abm & ~i_cpu_halted;
            ignored <= d_abm & ~i_cpu_halted;
            rxn <= (d_addr ? 5'd16 : 5'd0) + {d_wd, 3'b000};
            state <= (d_addr || d_wd != W_NONE) ? M_RX : M_ACC;
          end
          M_RX: if (bit_done) begin
            rsh <= {rsh[22:0], rx_bit};
            bitcnt <= bitcnt + 5'd1;
            if (bitcnt == rxn - 5'd1) state <= M_ACC;
          end
          M_ACC: begin
            // The access fits in the delay slot; the host waits it out.
            state <= M_WAIT;
            if (inhibit) begin
              act <= A_NONE;
            end else begin
              case (act)
                A_BGND: o_bgnd_req <= permit;
                A_WCTL: begin
                  if (!i_cpu_halted) permit <= rsh[`SWD_ST_PERMIT];
                  bkpt_en <= rsh[`SWD_ST_BKPT_EN];
                  force_tag_select <= rsh[`SWD_ST_FTS];
                  clksw <= rsh[`SWD_ST_CLKSW];
                end
                A_MATCH_OUT_FIELD: match <= word_out_field;
                A_MATCH_IN_FIELD: rdat <= match;
                A_GO: o_resume <= 1'b1;
                A_RESUME_TAGGED_CMD: o_resume_tagged <= 1'b1;
                A_TRACE: o_single_step <= 1'b1;
                A_MEMRD, A_MEMWR, A_RDLAST, A_NXTRD, A_NXTWR: begin
                  o_mem_req <= 1'b1;
                  o_mem_we <= (act == A_MEMWR) || (act == A_NXTWR);
                  o_mem_wdata <= rsh[7:0];
                  if (act == A_RDLAST) o_mem_addr <= last_addr;
                  else if (act == A_NXTRD || act == A_NXTWR) begin
                    o_mem_addr <= next_index;
                    o_index_inc <= 1'b1;
                  end else o_mem_addr <= addr_in;
                  if (act == A_MEMRD) last_addr <= addr_in;
                  if (act == A_NXTRD) last_addr <= next_index;
                end
                A_REGRD, A_REGWR: begin
                  o_reg_req <= 1'b1;
                  o_reg_we <= (act == A_REGWR);
                  o_reg_sel <= cmd[2:0];
                  o_reg_wdata <= (f_wd == W_BYTE) ? {8'h00, rsh[7:0]} : word_out_field;
                end
                default: act <= A_NONE;
              endcase
            end
          end
          M_WAIT: begin
            if (o_mem_req && !i_mem_ack) state <= M_WAIT;
            else if (o_reg_req && !i_reg_ack) state <= M_WAIT;
            else begin
              if (o_mem_req) rdat <= {8'h00, i_mem_rdata};
              if (o_reg_req) rdat <= i_reg_rdata;
              if (inhibit) rdat <= 16'h0000;
              o_mem_req <= 1'b0;
              o_reg_req <= 1'b0;
              bitcnt <= 5'd0;
              if (f_ss) begin
                sh <= {status, 8'h00};
                state <= M_TXS;
              end else if (f_rd != W_NONE) begin
                state <= M_TXD;
                sh <= 16'hffff;
                bitcnt <= 5'd31;
              end else state <= M_CMD;
            end
          end
          M_TXS: if (bit_done) begin
            sh <= {sh[14:0], 1'b1};
            bitcnt <= bitcnt + 5'd1;
            if (bitcnt == 5'd7) begin
              bitcnt <= 5'd0;
              sh <= (f_rd == W_BYTE) ? {rdat[7:0], 8'hff} : rdat;
              state <= (f_rd != W_NONE) ? M_TXD : M_CMD;
            end
          end
          M_TXD: begin
            if (bitcnt == 5'd31) begin
              // Data captured in the access or wait cycle is loaded here for replies without status.
              bitcnt <= 5'd0;
              sh <= (f_rd == W_BYTE) ? {rdat[7:0], 8'hff} : rdat;
            end else if (bit_done) begin
              sh <= {sh[14:0], 1'b1};
              bitcnt <= bitcnt + 5'd1;
              if (bitcnt == {f_rd, 3'b000} - 5'd1) begin
                bitcnt <= 5'd0;
                sh <= 16'hffff;
                state <= M_CMD;
              end
            end
          end
          default: state <= M_CMD;
        endcase
      end
    end
  end

  // ****************************************************************
  // Hardware breakpoint
  // ****************************************************************
  // A disabled breakpoint ignores the match value and select bit entirely.
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_force_bkpt <= 1'b0;
      o_tag_opcode <= 1'b0;
    end else begin
      o_force_bkpt <= bkpt_en & force_tag_select & i_cpu_access & (i_cpu_addr == match);
      o_tag_opcode <= bkpt_en & ~force_tag_select & i_opcode_fetch & (i_cpu_addr == match);
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Zero-wait slave: read data is captured in the setup cycle.
  wire apb_setup = i_psel & ~i_penable;
  wire apb_wr = i_psel & i_penable & i_pwrite;
  wire mapped = (i_paddr == `SWD_APB_STATUS) || (i_paddr == `SWD_APB_MATCH) ||
                (i_paddr == `SWD_APB_DIV) || (i_paddr == `SWD_APB_INFO);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h00000000;
      alt_div <= `SWD_ALT_DIV_RST;
    end else begin
      if (apb_setup) begin
        case (i_paddr)
          `SWD_APB_STATUS: o_prdata <= {24'h000000, status};
          `SWD_APB_MATCH: o_prdata <= {16'h0000, match};
          `SWD_APB_DIV: o_prdata <= {24'h000000, alt_div};
          `SWD_APB_INFO: o_prdata <= {22'h000000, tout_seen, ignored, cmd};
          default: o_prdata <= 32'h00000000;
        endcase
      end
      if (apb_wr && i_paddr == `SWD_APB_DIV) alt_div <= i_pwdata[7:0];
    end
  end

  // Sticky timeout flag; a new timeout in the clearing cycle wins.
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) tout_seen <= 1'b0;
    else if (timeout) tout_seen <= 1'b1;
    else if (apb_wr && i_paddr == `SWD_APB_INFO && i_pwdata[`SWD_INFO_TIMEOUT]) begin
      tout_seen <= 1'b0;
    end
  end
endmodule // swd_cmd_unit

// ===== swd_cmd_checker.sv
// Concurrent checks on the ports of the debug command unit.
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module swd_cmd_checker (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic o_debug_line,
  input wire logic o_debug_line_oe,
  input wire logic i_cpu_halted,
  input wire logic o_bgnd_req,
  input wire logic o_resume,
  input wire logic o_resume_tagged,
  input wire logic o_single_step,
  input wire logic o_reg_req,
  input wire logic o_mem_req,
  input wire logic [15:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic i_cpu_access,
  input wire logic i_opcode_fetch,
  input wire logic o_force_bkpt,
  input wire logic o_tag_opcode
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Breaks follow a bus cycle by one clock.
  AST_FORCE_CAUSE: assert property (o_force_bkpt |-> $past(i_cpu_access))
    else $error("forced break without an access");
  AST_TAG_CAUSE: assert property (o_tag_opcode |-> $past(i_opcode_fetch))
    else $error("tag without an opcode fetch");
  AST_ONE_KIND: assert property (!(o_force_bkpt && o_tag_opcode))
    else $error("forced and tagged break together");
  // Register and run control only while halted.
  AST_REG_HALTED: assert property ($rose(o_reg_req) |-> i_cpu_halted)
    else $error("register access while running");
  AST_RUN_HALTED: assert property ((o_resume || o_resume_tagged || o_single_step)
    |-> i_cpu_halted) else $error("run control while running");
  AST_BGND_PULSE: assert property (o_bgnd_req |=> !o_bgnd_req)
    else $error("background request longer than a cycle");
  // A request holds until answered.
  AST_MEM_HOLD: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
    else $error("memory request moved before its answer");
  // Each drive ends high before release.
  AST_RELEASE_HIGH: assert property ($fell(o_debug_line_oe) |-> $past(o_debug_line))
    else $error("line released while driven low");
endmodule // swd_cmd_checker
bind swd_cmd_unit swd_cmd_checker u_swd_cmd_checker (.*);

// ===== swd_pod.sv
// Behavioural debug pod at the host end of the debug line.
`timescale 1ns/1ps
// ****************
// Debug pod
// ****************
module swd_pod (
  input wire logic i_core_clk,
  input wire logic i_line,
  output logic o_pull_low
);
  // Pull-up gives the high level.
  initial o_pull_low = 1'h0;
  // Send MSB first; long low 0, short low 1.
  task automatic put(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge i_core_clk);
      o_pull_low <= 1'h1;
      repeat (v[i] ? 4 : 16) @(posedge i_core_clk);
      o_pull_low <= 1'h0;
      repeat (v[i] ? 22 : 10) @(posedge i_core_clk);
    end
  endtask
  // Reply bits: short low, sample mid-bit.
  task automatic get(input int n, output logic [31:0] v);
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      @(posedge i_core_clk);
      o_pull_low <= 1'h1;
      repeat (2) @(posedge i_core_clk);
      o_pull_low <= 1'h0;
      repeat (10) @(posedge i_core_clk);
      v = {v[30:0], i_line};
      repeat (14) @(posedge i_core_clk);
    end
  endtask
  // One whole command; the wait outlasts a slot.
  task automatic cmd(input logic [7:0] c, input logic [31:0] o, input int no, input int ni,
                     output logic [31:0] r);
    put({24'h0, c}, 8);
    put(o, no);
    repeat (40) @(posedge i_core_clk);
    get(ni, r);
  endtask
  // Speed request; count reply low.
  task automatic sync(output int n);
    o_pull_low <= 1'h1;
    repeat (150) @(posedge i_core_clk);
    o_pull_low <= 1'h0;
    @(posedge i_core_clk);
    while (i_line) @(posedge i_core_clk);
    for (n = 0; !i_line; n++) @(posedge i_core_clk);
  endtask
endmodule // swd_pod

// ===== single_wire_debug_command_unit_tb.sv
// Self-checking bench of the debug command unit.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
// ****************
// Bench
// ****************
module single_wire_debug_command_unit_tb;
  logic i_core_clk = 1'h0, i_rst = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
  logic i_cpu_halted = 1'h0, i_reg_ack = 1'h0, i_mem_ack = 1'h0, i_cpu_access = 1'h0;
  logic i_opcode_fetch = 1'h0, pull_low, o_pready, o_pslverr, o_debug_line, o_debug_line_oe;
  logic o_bgnd_req, o_resume, o_resume_tagged, o_single_step, o_reg_req, o_reg_we, err;
  logic o_index_inc, o_mem_req, o_mem_we, o_force_bkpt, o_tag_opcode;
  logic [2:0] o_reg_sel, wr_sel = 3'h0;
  logic [7:0] i_paddr = 8'h00, i_mem_rdata = 8'h00, o_mem_wdata, data, mem_arr [0:65535];
  logic [15:0] i_reg_rdata = 16'h0, i_index = 16'h0, i_cpu_addr = 16'h0, o_reg_wdata;
  logic [15:0] o_mem_addr, wr_val = 16'h0, match, addr, rv;
  logic [31:0] i_pwdata = 32'h0, o_prdata, r;
  logic [7:0] exp_mem [int];
  int n_mismatch = 0, samples_checked = 0, seed = 87, n;
  wire i_debug_line = ~(pull_low | (o_debug_line_oe & ~o_debug_line));
  swd_cmd_unit u_swd_cmd_unit (.*);
  swd_pod u_swd_pod (.i_core_clk(i_core_clk), .i_line(i_debug_line), .o_pull_low(pull_low));
  // Free-running core clock, 8 ns period.
  always #4 i_core_clk = ~i_core_clk;
  // CPU side: late answers make each request hold.
  always @(posedge i_core_clk) begin
    i_mem_ack <= o_mem_req & ~i_mem_ack;
    i_mem_rdata <= mem_arr[o_mem_addr];
    if (o_mem_req & ~i_mem_ack & o_mem_we) mem_arr[o_mem_addr] <= o_mem_wdata;
    i_reg_ack <= o_reg_req & ~i_reg_ack;
    if (o_reg_req & o_reg_we) {wr_sel, wr_val} <= {o_reg_sel, o_reg_wdata};
    if (o_bgnd_req) i_cpu_halted <= 1'h1;
    if (o_resume | o_resume_tagged | o_single_step) i_cpu_halted <= 1'h0;
  end
  // One bus transfer; waits for ready.
  task automatic apb(input logic w, input logic [7:0] a);
    @(posedge i_core_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'h2, w, a, 32'h0};
    @(posedge i_core_clk);
    i_penable <= 1'h1;
    do @(posedge i_core_clk); while (o_pready !== 1'h1);
    r = o_prdata;
    err = o_pslverr;
    {i_psel, i_penable} <= 2'h0;
  endtask
  // One bus cycle, then both break outputs.
  task automatic hit(input logic f, input logic [15:0] a, input logic ef, input logic et);
    @(posedge i_core_clk);
    {i_cpu_addr, i_cpu_access, i_opcode_fetch} <= {a, 1'h1, f};
    @(posedge i_core_clk);
    {i_cpu_access, i_opcode_fetch} <= 2'h0;
    @(posedge i_core_clk);
    `CHK(o_force_bkpt, ef)
    `CHK(o_tag_opcode, et)
  endtask
  // Counts, verdict and the end of the run.
  task automatic report_and_stop;
    $display("compared %0d, mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard, far above the sequence.
  initial begin
    repeat (80000) @(posedge i_core_clk);
    n_mismatch++;
    report_and_stop();
  end
  // Main sequence; divider 0 ticks every cycle.
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'h0;
    {match, addr, data, rv} = {16'($random(seed)), 16'($random(seed)), 8'($random(seed)),
                               16'($random(seed))};
    i_reg_rdata <= rv;
    hit(1'h0, 16'h0000, 1'h0, 1'h0);
    apb(1'h1, 8'h08);
    apb(1'h0, 8'h20);
    `CHK({err, r}, {1'h1, 32'h0})
    u_swd_pod.cmd(8'h90, 32'h0, 0, 0, r);
    `CHK(i_cpu_halted, 1'h0)
    u_swd_pod.cmd(8'hc4, 32'hb8, 8, 0, r);
    u_swd_pod.cmd(8'he4, 32'h0, 0, 8, r);
    `CHK(r[7:0], 8'hb8)
    apb(1'h0, 8'h00);
    `CHK(r, 32'hb8)
    u_swd_pod.cmd(8'hc2, {16'h0, match}, 16, 0, r);
    u_swd_pod.cmd(8'he2, 32'h0, 0, 16, r);
    `CHK(r[15:0], match)
    apb(1'h0, 8'h04);
    `CHK(r[15:0], match)
    hit(1'h0, match, 1'h1, 1'h0);
    hit(1'h0, ~match, 1'h0, 1'h0);
    exp_mem[addr] = data;
    u_swd_pod.cmd(8'hc1, {8'h0, addr, data}, 24, 8, r);
    `CHK({r[7:0], mem_arr[addr]}, {8'hb8, exp_mem[addr]})
    u_swd_pod.cmd(8'he1, {16'h0, addr}, 16, 16, r);
    `CHK(r[15:0], {8'hb8, exp_mem[addr]})
    u_swd_pod.cmd(8'he8, 32'h0, 0, 16, r);
    `CHK(r[15:0], {8'hb8, exp_mem[addr]})
    u_swd_pod.cmd(8'h68, 32'h0, 0, 8, r);
    `CHK(r[7:0], 8'h00)
    u_swd_pod.cmd(8'h90, 32'h0, 0, 0, r);
    `CHK(i_cpu_halted, 1'h1)
    u_swd_pod.cmd(8'h6b, 32'h0, 0, 16, r);
    `CHK(r[15:0], rv)
    u_swd_pod.cmd(8'h4f, {16'h0, ~rv}, 16, 0, r);
    `CHK({wr_sel, wr_val}, {3'h7, ~rv})
    u_swd_pod.cmd(8'he4, 32'h0, 0, 8, r);
    `CHK(r[7:0], 8'hf8)
    u_swd_pod.cmd(8'h08, 32'h0, 0, 0, r);
    `CHK(i_cpu_halted, 1'h0)
    u_swd_pod.cmd(8'hc4, 32'ha8, 8, 0, r);
    hit(1'h1, match, 1'h0, 1'h1);
    u_swd_pod.sync(n);
    `CHK(n, 128)
    report_and_stop();
  end
endmodule // single_wire_debug_command_unit_tb
